// *** core/boot_osc_segment_cfg.sv ***
/*
 Boot configuration block: the segment protection byte and the oscillator
 selection byte, latched from nonvolatile inputs at reset release, readable over
 AXI4-Lite. Protection bits may only be cleared by software.
 Assumes nvProtByte and nvOscByte are stable around reset release.
*/
`timescale 1ns/1ps
`include "boot_cfg_cfg.svh"
module boot_osc_segment_cfg
    import boot_cfg_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] nvProtByte,
    input wire logic [7:0] nvOscByte,
    input wire logic segWriteReq,
    output logic segWriteAllowed,
    output logic segCodeProtected,
    output logic twoSpeedStartupEn,
    output logic lowpowerRcHighPower,
    output logic secondaryCrystalEn,
    output logic secondaryDigitalClockIn,
    output osc_source_t oscSource,
    output logic [7:0] oscSourceOneHot,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic loaded_reg, loaded_next;
    logic [7:0] prot_reg, prot_next;
    logic [7:0] osc_reg, osc_next;
    logic [7:0] nvProt_reg, nvProt_next;
    logic [7:0] nvOsc_reg, nvOsc_next;
    wr_state_t wst_reg, wst_next;
    logic awHeld_reg, awHeld_next;
    logic wHeld_reg, wHeld_next;
    logic [3:0] awAddr_reg, awAddr_next;
    logic [7:0] wByte_reg, wByte_next;
    logic wLane_reg, wLane_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [5:0] outs_reg, outs_next;
    osc_source_t src_reg;
    logic [7:0] hot_reg;
    osc_source_t srcDec;
    logic [7:0] hotDec;
    logic doWrite;

    osc_source_decode u_dec (
        .oscSourceSelect(osc_reg[2:0]),
        .oscSource(srcDec),
        .oscOneHot(hotDec)
    );

    assign doWrite = awHeld_reg && wHeld_reg && (wst_reg == WR_IDLE);

    // Configuration capture and clear-only protection bits.
    always_comb
    begin
        loaded_next = 1'b1;
        nvProt_next = nvProt_reg;
        nvOsc_next = nvOsc_reg;
        prot_next = prot_reg;
        osc_next = osc_reg;
        if (!loaded_reg)
        begin
            prot_next = nvProtByte & `MASK_PROT;
            osc_next = nvOscByte & `MASK_OSC;
            nvProt_next = nvProtByte & `MASK_PROT;
            nvOsc_next = nvOscByte & `MASK_OSC;
        end
        else if (doWrite && wLane_reg && awAddr_reg == `ADDR_PROT_CFG)
        begin
            prot_next = prot_reg & (wByte_reg | ~`MASK_PROT);
        end
    end

    // Write channel: address and data taken in either order.
    always_comb
    begin
        wst_next = wst_reg;
        awHeld_next = awHeld_reg;
        wHeld_next = wHeld_reg;
        awAddr_next = awAddr_reg;
        wByte_next = wByte_reg;
        wLane_next = wLane_reg;
        bresp_next = bresp_reg;
        if (s_axi_awvalid && !awHeld_reg && wst_reg == WR_IDLE)
        begin
            awHeld_next = 1'b1;
            awAddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wHeld_reg && wst_reg == WR_IDLE)
        begin
            wHeld_next = 1'b1;
            wByte_next = s_axi_wdata[7:0];
            wLane_next = s_axi_wstrb[0];
        end
        case (wst_reg)
            WR_IDLE:
            begin
                if (doWrite)
                begin
                    wst_next = WR_RESP;
                    awHeld_next = 1'b0;
                    wHeld_next = 1'b0;
                    if (awAddr_reg == `ADDR_PROT_CFG || awAddr_reg == `ADDR_OSC_CFG)
                    begin
                        bresp_next = `RESP_OKAY;
                    end
                    else
                    begin
                        bresp_next = `RESP_SLVERR;
                    end
                end
            end
            default:
            begin
                if (s_axi_bready)
                begin
                    wst_next = WR_IDLE;
                end
            end
        endcase
    end

    // Read channel; unimplemented bits are masked to zero.
    always_comb
    begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && s_axi_rready)
        begin
            rvalid_next = 1'b0;
        end
        else if (!rvalid_reg && s_axi_arvalid)
        begin
            rvalid_next = 1'b1;
            rresp_next = `RESP_OKAY;
            if (s_axi_araddr == `ADDR_PROT_CFG)
            begin
                rdata_next = {24'h0, prot_reg & `MASK_PROT};
            end
            else if (s_axi_araddr == `ADDR_OSC_CFG)
            begin
                rdata_next = {24'h0, osc_reg & `MASK_OSC};
            end
            else if (s_axi_araddr == `ADDR_NV_PROT)
            begin
                rdata_next = {24'h0, nvProt_reg};
            end
            else if (s_axi_araddr == `ADDR_NV_OSC)
            begin
                rdata_next = {24'h0, nvOsc_reg};
            end
            else
            begin
                rdata_next = 32'h0;
                rresp_next = `RESP_SLVERR;
            end
        end
    end

    // Applied control outputs, from the latched bytes and segWriteReq.
    always_comb
    begin
        outs_next[0] = prot_reg[`BIT_WRITE_PROT] & segWriteReq;
        outs_next[1] = ~prot_reg[`BIT_CODE_PROT];
        outs_next[2] = osc_reg[`BIT_TWO_SPEED];
        outs_next[3] = osc_reg[`BIT_LOWPOWER_RC_OSC_PWR];
        outs_next[4] = osc_reg[`BIT_PINFUNC];
        outs_next[5] = ~osc_reg[`BIT_PINFUNC];
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loaded_reg <= 1'b0;
            prot_reg <= `RST_PROT;
            osc_reg <= `RST_OSC;
            nvProt_reg <= `RST_PROT;
            nvOsc_reg <= `RST_OSC;
            wst_reg <= WR_IDLE;
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= 4'h0;
            wByte_reg <= 8'h0;
            wLane_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= `RESP_OKAY;
            // Outputs start out matching the reset bytes, so that nothing jumps at release.
            outs_reg <= `RST_OUTS;
            src_reg <= FAST_RC_OSC_DIVIDED;
            hot_reg <= `RST_HOT;
        end
        else
        begin
            loaded_reg <= loaded_next;
            prot_reg <= prot_next;
            osc_reg <= osc_next;
            nvProt_reg <= nvProt_next;
            nvOsc_reg <= nvOsc_next;
            wst_reg <= wst_next;
            awHeld_reg <= awHeld_next;
            wHeld_reg <= wHeld_next;
            awAddr_reg <= awAddr_next;
            wByte_reg <= wByte_next;
            wLane_reg <= wLane_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            outs_reg <= outs_next;
            src_reg <= srcDec;
            hot_reg <= hotDec;
        end
    end

    assign segWriteAllowed = outs_reg[0];
    assign segCodeProtected = outs_reg[1];
    assign twoSpeedStartupEn = outs_reg[2];
    assign lowpowerRcHighPower = outs_reg[3];
    assign secondaryCrystalEn = outs_reg[4];
    assign secondaryDigitalClockIn = outs_reg[5];
    assign oscSource = src_reg;
    assign oscSourceOneHot = hot_reg;
    assign s_axi_awready = !awHeld_reg && wst_reg == WR_IDLE;
    assign s_axi_wready = !wHeld_reg && wst_reg == WR_IDLE;
    assign s_axi_bvalid = (wst_reg == WR_RESP);
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    property p_osc_hold;
        @(posedge mclk) disable iff (!rst_n) loaded_reg && $past(loaded_reg) |-> $stable(osc_reg);
    endproperty
    a_osc_hold: assert property (p_osc_hold) else $error("osc byte changed");
    property p_prot_noset;
        @(posedge mclk) disable iff (!rst_n)
            loaded_reg && $past(loaded_reg) |-> (prot_reg & ~$past(prot_reg)) == 8'h0;
    endproperty
    a_prot_noset: assert property (p_prot_noset) else $error("prot bit set");
    property p_unimpl;
        @(posedge mclk) disable iff (!rst_n)
            rvalid_reg |-> rdata_reg[31:8] == 24'h0 && (prot_reg & ~`MASK_PROT) == 8'h0
                && (osc_reg & ~`MASK_OSC) == 8'h0;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("upper read bits");
    property p_wp;
        @(posedge mclk) disable iff (!rst_n) segWriteAllowed |-> $past(prot_reg[`BIT_WRITE_PROT]);
    endproperty
    a_wp: assert property (p_wp) else $error("write not refused");
    property p_cp;
        @(posedge mclk) disable iff (!rst_n)
            ##1 segCodeProtected == !$past(prot_reg[`BIT_CODE_PROT]);
    endproperty
    a_cp: assert property (p_cp) else $error("code protect wrong");
    property p_ts;
        @(posedge mclk) disable iff (!rst_n)
            ##1 twoSpeedStartupEn == $past(osc_reg[`BIT_TWO_SPEED]);
    endproperty
    a_ts: assert property (p_ts) else $error("two-speed wrong");
    property p_lp;
        @(posedge mclk) disable iff (!rst_n)
            ##1 lowpowerRcHighPower == $past(osc_reg[`BIT_LOWPOWER_RC_OSC_PWR]);
    endproperty
    a_lp: assert property (p_lp) else $error("lowpower_rc_osc power wrong");
    property p_pin;
        @(posedge mclk) disable iff (!rst_n) secondaryCrystalEn != secondaryDigitalClockIn;
    endproperty
    a_pin: assert property (p_pin) else $error("pin function clash");
    property p_src;
        @(posedge mclk) disable iff (!rst_n) ##1 oscSource == osc_source_t'($past(osc_reg[2:0]));
    endproperty
    a_src: assert property (p_src) else $error("source decode wrong");
    property p_hot;
        @(posedge mclk) disable iff (!rst_n) ##1 oscSourceOneHot[$past(osc_reg[2:0])];
    endproperty
    a_hot: assert property (p_hot) else $error("one-hot wrong");
    property p_bresp;
        @(posedge mclk) disable iff (!rst_n) doWrite |=> s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("no write response");
    c_write: cover property (@(posedge mclk) disable iff (!rst_n) s_axi_bvalid && s_axi_bready);
    c_read: cover property (@(posedge mclk) disable iff (!rst_n) s_axi_rvalid && s_axi_rready);
    c_clear: cover property (@(posedge mclk) disable iff (!rst_n) $fell(prot_reg[0]));
endmodule

// *** inc/boot_cfg_cfg.svh ***
/*
 Constants for the boot configuration block: register offsets, field positions,
 reset values and bus response codes. Included by bare name.
*/
`ifndef BOOT_CFG_CFG_SVH
`define BOOT_CFG_CFG_SVH
`define ADDR_PROT_CFG 4'h0
`define ADDR_OSC_CFG 4'h4
`define ADDR_NV_PROT 4'h8
`define ADDR_NV_OSC 4'hc
`define BIT_WRITE_PROT 0
`define BIT_CODE_PROT 1
`define BIT_PINFUNC 5
`define BIT_LOWPOWER_RC_OSC_PWR 6
`define BIT_TWO_SPEED 7
`define MASK_PROT 8'h03
`define MASK_OSC 8'he7
`define RST_PROT 8'h03
`define RST_OSC 8'he7
`define RST_OUTS 6'h1c
`define RST_HOT 8'h80
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** inc/boot_cfg_pkg.sv ***
/*
 Types shared by the boot configuration block.
 Assumes the constants header is included by the files that need numbers.
*/
package boot_cfg_pkg;
    typedef enum logic [2:0] {
        FAST_RC_OSC,
        FAST_RC_DIVIDED_WITH_PLL,
        PRIMARY_OSC,
        PRIMARY_OSC_PLL,
        SECONDARY_OSC,
        LOWPOWER_RC_OSC,
        LOWPOWER_FAST_RC_DIVIDED,
        FAST_RC_OSC_DIVIDED
    } osc_source_t;
    typedef enum logic [1:0] {
        WR_IDLE,
        WR_RESP
    } wr_state_t;
endpackage

// *** core/osc_source_decode.sv ***
/*
 Decodes the three-bit oscillator source select field into a source type and
 per-source one-hot flags. Pure combinational; the caller registers outputs.
*/
`timescale 1ns/1ps
`include "boot_cfg_cfg.svh"
module osc_source_decode
    import boot_cfg_pkg::*;
(
    input wire logic [2:0] oscSourceSelect,
    output osc_source_t oscSource,
    output logic [7:0] oscOneHot
);
    always_comb
    begin
        case (oscSourceSelect)
            3'h0: oscSource = FAST_RC_OSC;
            3'h1: oscSource = FAST_RC_DIVIDED_WITH_PLL;
            3'h2: oscSource = PRIMARY_OSC;
            3'h3: oscSource = PRIMARY_OSC_PLL;
            3'h4: oscSource = SECONDARY_OSC;
            3'h5: oscSource = LOWPOWER_RC_OSC;
            3'h6: oscSource = LOWPOWER_FAST_RC_DIVIDED;
            default: oscSource = FAST_RC_OSC_DIVIDED;
        endcase
    end

    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_hot
            assign oscOneHot[i] = (oscSourceSelect == 3'(i));
        end
    endgenerate
endmodule

// *** sim/boot_osc_segment_cfg_bench.sv ***
/*
 Self-checking bench for the boot configuration block: register reads and
 writes over AXI4-Lite, decode of every source code, clear-only protection bits.
 Assumes the design package and constants header are compiled first.
*/
`timescale 1ns/1ps
`include "boot_cfg_cfg.svh"
module boot_osc_segment_cfg_bench
    import boot_cfg_pkg::*;
;
    logic mclk, rst_n, segWriteReq, segWriteAllowed, segCodeProtected;
    logic twoSpeedStartupEn, lowpowerRcHighPower, secondaryCrystalEn;
    logic secondaryDigitalClockIn;
    logic [7:0] nvProtByte, nvOscByte, oscSourceOneHot;
    osc_source_t oscSource;
    logic [3:0] awaddr, araddr, wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    int fails = 0;
    int samplesChecked = 0;
    int cycles = 0;
    osc_source_t srcTable [8] = '{FAST_RC_OSC, FAST_RC_DIVIDED_WITH_PLL, PRIMARY_OSC,
        PRIMARY_OSC_PLL, SECONDARY_OSC, LOWPOWER_RC_OSC, LOWPOWER_FAST_RC_DIVIDED,
        FAST_RC_OSC_DIVIDED};

    boot_osc_segment_cfg dut (.mclk(mclk), .rst_n(rst_n), .nvProtByte(nvProtByte),
        .nvOscByte(nvOscByte), .segWriteReq(segWriteReq), .segWriteAllowed(segWriteAllowed),
        .segCodeProtected(segCodeProtected), .twoSpeedStartupEn(twoSpeedStartupEn),
        .lowpowerRcHighPower(lowpowerRcHighPower), .secondaryCrystalEn(secondaryCrystalEn),
        .secondaryDigitalClockIn(secondaryDigitalClockIn), .oscSource(oscSource),
        .oscSourceOneHot(oscSourceOneHot), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task final_report;
        if (fails == 0 && samplesChecked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            fails = fails + 1;
            final_report;
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked = samplesChecked + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Both channels are offered together and each is released when taken.
    task axiWrite(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        r = 2'h1;
        do
        begin
            @(posedge mclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        while (!(bvalid && bready));
        r = bresp;
        bready <= 1'b0;
    endtask

    task axiRead(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        while (!(rvalid && rready));
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task doReset(input logic [7:0] prot, input logic [7:0] osc);
        @(posedge mclk);
        nvProtByte <= prot;
        nvOscByte <= osc;
        rst_n <= 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask

    task readCheck(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] expResp);
        logic [31:0] d;
        logic [1:0] r;
        axiRead(a, d, r);
        check(d, exp);
        check({30'h0, r}, {30'h0, expResp});
    endtask

    initial
    begin
        logic [7:0] osc;
        logic [1:0] r;
        rst_n = 1'b0;
        nvProtByte = 8'hff;
        nvOscByte = 8'hff;
        segWriteReq = 1'b0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        for (int i = 0; i < 8; i++)
        begin
            osc = {i[0], i[1], ~i[0], 2'b11, i[2:0]};
            doReset(8'hff, osc);
            check({29'h0, oscSource}, {29'h0, srcTable[i]});
            check({24'h0, oscSourceOneHot}, {24'h0, 8'h01 << i});
            check({31'h0, twoSpeedStartupEn}, {31'h0, osc[7]});
            check({31'h0, lowpowerRcHighPower}, {31'h0, osc[6]});
            check({30'h0, secondaryCrystalEn, secondaryDigitalClockIn},
                {30'h0, osc[5], ~osc[5]});
            readCheck(`ADDR_OSC_CFG, {24'h0, osc & 8'he7}, `RESP_OKAY);
            readCheck(`ADDR_NV_OSC, {24'h0, osc & 8'he7}, `RESP_OKAY);
        end
        // The stored oscillator byte ignores later changes of the nonvolatile inputs and bus writes.
        nvOscByte <= 8'h00;
        axiWrite(`ADDR_OSC_CFG, 32'h0, r);
        check({30'h0, r}, {30'h0, `RESP_OKAY});
        check({29'h0, oscSource}, {29'h0, FAST_RC_OSC_DIVIDED});
        readCheck(`ADDR_OSC_CFG, {24'h0, osc & 8'he7}, `RESP_OKAY);
        doReset(8'hff, 8'h00);
        readCheck(`ADDR_PROT_CFG, 32'h3, `RESP_OKAY);
        check({31'h0, segCodeProtected}, 32'h0);
        check({31'h0, segWriteAllowed}, 32'h0);
        segWriteReq <= 1'b1;
        repeat (3) @(posedge mclk);
        check({31'h0, segWriteAllowed}, 32'h1);
        axiWrite(`ADDR_PROT_CFG, 32'h2, r);
        check({30'h0, r}, {30'h0, `RESP_OKAY});
        readCheck(`ADDR_PROT_CFG, 32'h2, `RESP_OKAY);
        repeat (3) @(posedge mclk);
        check({31'h0, segWriteAllowed}, 32'h0);
        axiWrite(`ADDR_PROT_CFG, 32'h3, r);
        readCheck(`ADDR_PROT_CFG, 32'h2, `RESP_OKAY);
        axiWrite(`ADDR_PROT_CFG, 32'h1, r);
        readCheck(`ADDR_PROT_CFG, 32'h0, `RESP_OKAY);
        repeat (3) @(posedge mclk);
        check({31'h0, segCodeProtected}, 32'h1);
        nvProtByte <= 8'hfe;
        repeat (3) @(posedge mclk);
        readCheck(`ADDR_PROT_CFG, 32'h0, `RESP_OKAY);
        doReset(8'hfd, 8'h00);
        readCheck(`ADDR_PROT_CFG, 32'h1, `RESP_OKAY);
        readCheck(`ADDR_NV_PROT, 32'h1, `RESP_OKAY);
        check({31'h0, segCodeProtected}, 32'h1);
        check({31'h0, segWriteAllowed}, 32'h1);
        readCheck(4'h2, 32'h0, `RESP_SLVERR);
        axiWrite(4'h2, 32'h0, r);
        check({30'h0, r}, {30'h0, `RESP_SLVERR});
        final_report;
    end
endmodule
